// ==== rtl/rate_divider.sv ====
// conversion interval timer of the monitor
// assumes one system clock; run low holds the timer at its start
`timescale 1ns/1ps
`include "temp_mon_cfg.svh"
module rate_divider import temp_mon_pkg::*; #(
  parameter int BASE_TICK_CYCLES = `BASE_TICK_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // control
  input wire logic run,
  input wire logic [3:0] rate_code,
  // conversion request
  output logic conv_start
);
  logic [19:0] pre;
  logic [10:0] ivl;
  logic [3:0] eff_code;
  logic [10:0] ivl_len;

  // reserved codes run at the fastest rate
  assign eff_code = (rate_code > `RATE_MAX_CODE) ? `RATE_MAX_CODE : rate_code;
  assign ivl_len = 11'h001 << (`RATE_MAX_CODE - eff_code); // R11 R12

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre <= 20'h0_0000;
      ivl <= 11'h000;
    end else if (!run) begin
      pre <= 20'h0_0000;
      ivl <= 11'h000;
    end else if (pre == 20'(BASE_TICK_CYCLES - 1)) begin
      pre <= 20'h0_0000;
      ivl <= (ivl >= ivl_len - 11'h001) ? 11'h000 : ivl + 11'h001;
    end else begin
      pre <= pre + 20'h0_0001;
    end
  end

  // a pulse at the first cycle of every interval
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= run && pre == 20'h0_0000 && ivl == 11'h000; // R14
    end
  end
endmodule : rate_divider

// ==== rtl/temp_link_if.sv ====
// two-wire link between host controller and monitor
// assumes a pull-up on the data wire; clock is driven by the host only
`timescale 1ns/1ps
interface temp_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // open drain: any enabled low driver pulls the wire down
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe,
    input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : temp_link_if

// ==== rtl/temp_mon_cfg.svh ====
// constants of the temperature monitor register bank and its serial link
// assumes both ends share one system clock rate and this one header
//
// Summary of operation
// (R1) first byte after address loads the pointer
// (R2) second byte writes pointed register; reads follow pointer
// (R3) pointer resets to zero, local value
// (R4) temperature values read-only, converter-written, reset zero
// (R5) config read 0x03, write 0x09, reserved kept; the code stores reserved bits as zero
// (R6) config bit 7 masks limit interrupt output
// (R7) config bit 6 standby halts conversions only
// (R8) outputs stay live and re-evaluate in standby
// (R9) config bit 5 selects pin 6 function
// (R10) config bit 2 selects extended measurement range
// (R11) rate read 0x04, write 0x0a, divider
// (R12) codes 0 to 0x0a double rate each
// (R13) rate resets to 0x08; upper nibble zero
// (R14) each interval start converts both channels
// (R15) above high or at/below low trips
// (R16) overtemp outputs low on exceeded limits
// (R17) one shared hysteresis register at 0x21
// (R18) range switch leaves limits; host rewrites them
// (R19) all limits and hysteresis host readable writable
// (R20) overtemp releases at limit minus hysteresis
// (R21) extended range uses offset binary coding
// (R22) average at slow rates, none from 16
// (R23) writes to read-only or empty addresses ignored
// (R24) pointer-only write changes nothing else
`ifndef TEMP_MON_CFG_SVH
`define TEMP_MON_CFG_SVH

// slave address on the link, value arbitrary
`define DEV_ADDR 7'h2A

`define A_LOCAL_TEMP 8'h00
`define A_REMOTE_HI 8'h01
`define A_CONFIG_RD 8'h03
`define A_RATE_RD 8'h04
`define A_LOC_HIGH_RD 8'h05
`define A_LOC_LOW_RD 8'h06
`define A_REM_HIGH_HI_RD 8'h07
`define A_REM_LOW_HI_RD 8'h08
`define A_CONFIG_WR 8'h09
`define A_RATE_WR 8'h0A
`define A_LOC_HIGH_WR 8'h0B
`define A_LOC_LOW_WR 8'h0C
`define A_REM_HIGH_HI_WR 8'h0D
`define A_REM_LOW_HI_WR 8'h0E
`define A_REMOTE_LO 8'h10
`define A_HYST 8'h21
`define A_REM_HIGH_LO 8'h30
`define A_REM_LOW_LO 8'h31
`define A_LOC_OT 8'h32
`define A_REM_OT 8'h33

`define PTR_RESET 8'h00
`define TEMP_RESET 8'h00
`define CONFIG_RESET 8'h00
`define RATE_RESET 8'h08
`define HYST_RESET 8'h0A
`define HIGH_LIM_RESET 8'h55
`define LOW_LIM_RESET 8'h00
`define OT_LIM_RESET 8'h55

`define CFG_MASK_BIT 7
`define CFG_STANDBY_BIT 6
`define CFG_PIN6_BIT 5
`define CFG_RANGE_BIT 2
`define CFG_WRITABLE 8'hE4
`define RATE_CODE_MASK 8'h0F
`define RATE_MAX_CODE 4'hA
`define AVG_MAX_CODE 4'h7

// link bit period in system clocks, and event phases within it
`define PH_SDA_CHANGE 4'h4
`define PH_STOP_RELEASE 4'hC
`define PH_SAMPLE 4'hD
`define PH_LAST 4'hF

`define SYS_CLK_HZ 50000000
// interval of the fastest rate code, in microseconds
`define FASTEST_INTERVAL_US 15625
`define BASE_TICK_CYCLES (`SYS_CLK_HZ / 1000000 * `FASTEST_INTERVAL_US)

`endif

// ==== rtl/temp_mon_dev.sv ====
// monitor end: link slave, register bank, limit comparison, outputs
// assumes a converter on sys_clk answering conv_start with conv_done
`timescale 1ns/1ps
`include "temp_mon_cfg.svh"
module temp_mon_dev import temp_mon_pkg::*; #(
  parameter int BASE_TICK_CYCLES = `BASE_TICK_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // link to the host
  temp_link_if.dev link,
  // converter
  output logic conv_start,
  output logic avg_en,
  output logic range_ext,
  input wire logic conv_done,
  input wire logic [7:0] local_result,
  input wire logic [7:0] remote_result_hi,
  input wire logic [7:0] remote_result_lo,
  // alarm pins
  output logic overtemp_out_n,
  output logic pin6_out_n
);
  dev_state_e state;
  logic [3:0] bitcnt;
  logic [1:0] byte_idx;
  byte_t shreg;
  logic rw;
  logic ack_seen;
  byte_t pointer;
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic rx_done, wr_stb;

  byte_t local_temp_value, remote_temp_high_byte, remote_temp_low_byte;
  byte_t config_reg, rate_reg, overtemp_hysteresis;
  byte_t loc_high, loc_low, rem_high_hi, rem_low_hi, rem_high_lo, rem_low_lo;
  byte_t loc_ot_lim, rem_ot_lim;
  logic loc_ot, rem_ot, loc_ot2, rem_ot2;
  logic [9:0] loc_t10, rem_t10, rem_high10, rem_low10;
  logic limit_trip;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic byte_t read_mux(input byte_t addr);
    byte_t v;
    v = 8'h00;
    case (addr)
      `A_LOCAL_TEMP: v = local_temp_value;
      `A_REMOTE_HI: v = remote_temp_high_byte;
      `A_REMOTE_LO: v = remote_temp_low_byte;
      `A_CONFIG_RD: v = config_reg;
      `A_RATE_RD: v = rate_reg;
      `A_LOC_HIGH_RD: v = loc_high;
      `A_LOC_LOW_RD: v = loc_low;
      `A_REM_HIGH_HI_RD: v = rem_high_hi;
      `A_REM_LOW_HI_RD: v = rem_low_hi;
      `A_REM_HIGH_LO: v = rem_high_lo;
      `A_REM_LOW_LO: v = rem_low_lo;
      `A_LOC_OT: v = loc_ot_lim;
      `A_REM_OT: v = rem_ot_lim;
      `A_HYST: v = overtemp_hysteresis;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_mux

  // comparator with release at limit minus hysteresis, quarter degrees
  function automatic logic hyst_trip(input logic on, input logic [9:0] t,
    input logic [9:0] lim, input byte_t h);
    logic [10:0] sum;
    sum = {1'b0, t} + {1'b0, h, 2'b00};
    return on ? (sum > {1'b0, lim}) : (t > lim);
  endfunction : hyst_trip

  ////////////////////////////////////////////////////////////////////////////
  // link input synchronisers and condition detection

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= link.scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 && !scl_s3;
  assign scl_fall = !scl_s2 && scl_s3;
  assign start_seen = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_seen = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  assign rx_done = state == st_rx && scl_fall && bitcnt == 4'h8;
  // only the second byte of a write touches a register
  assign wr_stb = rx_done && byte_idx == 2'h2 && !rw; // R2 R24

  ////////////////////////////////////////////////////////////////////////////
  // link slave

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= st_idle;
      bitcnt <= 4'h0;
      byte_idx <= 2'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      ack_seen <= 1'b0;
    end else if (start_seen) begin
      state <= st_rx;
      bitcnt <= 4'h0;
      byte_idx <= 2'h0;
    end else if (stop_seen) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
        end
        st_rx: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s2};
            bitcnt <= bitcnt + 4'h1;
          end else if (rx_done) begin
            if (byte_idx == 2'h0 && shreg[7:1] != `DEV_ADDR) begin
              state <= st_idle;
            end else begin
              state <= st_ack;
              if (byte_idx == 2'h0) begin
                rw <= shreg[0];
              end
            end
          end
        end
        st_ack: begin
          if (scl_fall) begin
            bitcnt <= 4'h0;
            if (byte_idx != 2'h3) begin
              byte_idx <= byte_idx + 2'h1;
            end
            if (byte_idx == 2'h0 && rw) begin
              state <= st_tx;
              shreg <= read_mux(pointer); // R2
            end else begin
              state <= st_rx;
            end
          end
        end
        st_tx: begin
          if (scl_fall) begin
            shreg <= {shreg[6:0], 1'b0};
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt == 4'h7) begin
              state <= st_tx_ack;
            end
          end
        end
        st_tx_ack: begin
          if (scl_rise) begin
            ack_seen <= !sda_s2;
          end else if (scl_fall) begin
            bitcnt <= 4'h0;
            shreg <= read_mux(pointer);
            state <= ack_seen ? st_tx : st_idle;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // pointer has no address of its own
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pointer <= `PTR_RESET; // R3
    end else if (rx_done && byte_idx == 2'h1 && !rw) begin
      pointer <= shreg; // R1
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = state == st_ack || (state == st_tx && !shreg[7]);

  ////////////////////////////////////////////////////////////////////////////
  // host-writable registers, live in standby as well

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      config_reg <= `CONFIG_RESET;
      rate_reg <= `RATE_RESET;
      overtemp_hysteresis <= `HYST_RESET; // R17
      loc_high <= `HIGH_LIM_RESET;
      loc_low <= `LOW_LIM_RESET;
      rem_high_hi <= `HIGH_LIM_RESET;
      rem_low_hi <= `LOW_LIM_RESET;
      rem_high_lo <= 8'h00;
      rem_low_lo <= 8'h00;
      loc_ot_lim <= `OT_LIM_RESET;
      rem_ot_lim <= `OT_LIM_RESET;
    end else if (wr_stb) begin
      case (pointer) // R19
        // reserved config bits are not stored and read as zero
        `A_CONFIG_WR: config_reg <= shreg & `CFG_WRITABLE; // R5
        `A_RATE_WR: rate_reg <= shreg & `RATE_CODE_MASK; // R11 R13
        `A_HYST: overtemp_hysteresis <= shreg; // R17
        `A_LOC_HIGH_WR: loc_high <= shreg;
        `A_LOC_LOW_WR: loc_low <= shreg;
        `A_REM_HIGH_HI_WR: rem_high_hi <= shreg;
        `A_REM_LOW_HI_WR: rem_low_hi <= shreg;
        `A_REM_HIGH_LO: rem_high_lo <= shreg;
        `A_REM_LOW_LO: rem_low_lo <= shreg;
        `A_LOC_OT: loc_ot_lim <= shreg;
        `A_REM_OT: rem_ot_lim <= shreg;
        default: begin // R23
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion scheduling and results

  rate_divider #(
    .BASE_TICK_CYCLES(BASE_TICK_CYCLES)
  ) u_rate (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .run(!config_reg[`CFG_STANDBY_BIT]), // R7
    .rate_code(rate_reg[3:0]),
    .conv_start(conv_start)
  );

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      avg_en <= 1'b0;
      range_ext <= 1'b0;
    end else begin
      avg_en <= rate_reg[3:0] <= `AVG_MAX_CODE; // R22
      // converter applies the 64 degree offset when set
      range_ext <= config_reg[`CFG_RANGE_BIT]; // R10 R21
    end
  end

  // only the converter writes these
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      local_temp_value <= `TEMP_RESET;
      remote_temp_high_byte <= `TEMP_RESET;
      remote_temp_low_byte <= `TEMP_RESET;
    end else if (conv_done) begin
      local_temp_value <= local_result; // R4
      remote_temp_high_byte <= remote_result_hi;
      remote_temp_low_byte <= remote_result_lo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // limit comparison; limits keep their coding across a range switch

  assign loc_t10 = {local_temp_value, 2'b00};
  assign rem_t10 = {remote_temp_high_byte, remote_temp_low_byte[7:6]};
  assign rem_high10 = {rem_high_hi, rem_high_lo[7:6]};
  assign rem_low10 = {rem_low_hi, rem_low_lo[7:6]};
  assign limit_trip = local_temp_value > loc_high ||
    local_temp_value <= loc_low || rem_t10 > rem_high10 ||
    rem_t10 <= rem_low10; // R15

  // compared every cycle, so a write in standby takes effect at once
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      loc_ot <= 1'b0;
      rem_ot <= 1'b0;
      loc_ot2 <= 1'b0;
      rem_ot2 <= 1'b0;
    end else begin
      loc_ot <= hyst_trip(loc_ot, loc_t10, {loc_ot_lim, 2'b00},
        overtemp_hysteresis); // R16 R20
      rem_ot <= hyst_trip(rem_ot, rem_t10, {rem_ot_lim, 2'b00},
        overtemp_hysteresis); // R16 R20
      loc_ot2 <= hyst_trip(loc_ot2, loc_t10, {loc_high, 2'b00},
        overtemp_hysteresis); // R16
      rem_ot2 <= hyst_trip(rem_ot2, rem_t10, rem_high10,
        overtemp_hysteresis); // R16
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      overtemp_out_n <= 1'b1;
      pin6_out_n <= 1'b1;
    end else begin
      overtemp_out_n <= !(loc_ot || rem_ot); // R8 R16
      if (config_reg[`CFG_PIN6_BIT]) begin // R9
        pin6_out_n <= !(loc_ot2 || rem_ot2);
      end else begin
        pin6_out_n <= !(limit_trip && !config_reg[`CFG_MASK_BIT]); // R6 R8
      end
    end
  end
endmodule : temp_mon_dev

// ==== rtl/temp_mon_host.sv ====
// host end: turns register commands into link transfers
// assumes one command at a time; reads use the current pointer
`timescale 1ns/1ps
`include "temp_mon_cfg.svh"
module temp_mon_host import temp_mon_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_ptr_only,
  input wire logic [7:0] cmd_ptr,
  input wire logic [7:0] cmd_data,
  // answer
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack,
  // link to the monitor
  temp_link_if.host link
);
  host_state_e state;
  logic [3:0] ph;
  logic [3:0] bi;
  logic [1:0] bidx, last_idx;
  logic rd;
  byte_t ptr_q, data_q, rxsh, cur_byte;
  logic cur_rx, nack, sda_oe, sda_s1, sda_s2;

  assign cmd_ready = state == h_idle;
  assign cur_rx = rd && bidx == 2'h1;
  assign cur_byte = (bidx == 2'h0) ? {`DEV_ADDR, rd} :
    (bidx == 2'h1) ? ptr_q : data_q; // R1
  assign link.scl = (state == h_byte || state == h_stop) ? ph[3] : 1'b1;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = sda_oe;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer, one link bit every sixteen clocks

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= h_idle;
      ph <= 4'h0;
      bi <= 4'h0;
      bidx <= 2'h0;
      last_idx <= 2'h0;
      rd <= 1'b0;
      ptr_q <= 8'h00;
      data_q <= 8'h00;
      rxsh <= 8'h00;
      nack <= 1'b0;
      sda_oe <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_nack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      ph <= (state == h_idle) ? 4'h0 : ph + 4'h1;
      case (state)
        h_idle: begin
          if (cmd_valid) begin
            state <= h_start;
            rd <= cmd_read;
            ptr_q <= cmd_ptr;
            // limit rewrites after a range switch pass through as given
            data_q <= cmd_data; // R18
            // reserved bits of config and rate are sent as zero
            if (cmd_ptr == `A_CONFIG_WR) begin
              data_q <= cmd_data & `CFG_WRITABLE; // R5
            end else if (cmd_ptr == `A_RATE_WR) begin
              data_q <= cmd_data & `RATE_CODE_MASK; // R13
            end
            last_idx <= (cmd_read || cmd_ptr_only) ? 2'h1 : 2'h2;
            bidx <= 2'h0;
            bi <= 4'h0;
            nack <= 1'b0;
          end
        end
        h_start: begin
          if (ph == 4'h8) begin
            sda_oe <= 1'b1;
          end
          if (ph == `PH_LAST) begin
            state <= h_byte;
          end
        end
        h_byte: begin
          if (ph == `PH_SDA_CHANGE) begin
            sda_oe <= (bi < 4'h8 && !cur_rx) ? !cur_byte[3'(4'h7 - bi)] : 1'b0;
          end
          if (ph == `PH_SAMPLE) begin
            if (bi < 4'h8 && cur_rx) begin
              rxsh <= {rxsh[6:0], sda_s2};
            end else if (bi == 4'h8 && !cur_rx && sda_s2) begin
              nack <= 1'b1;
            end
          end
          if (ph == `PH_LAST) begin
            if (bi == 4'h8) begin
              bi <= 4'h0;
              if (nack || bidx == last_idx) begin
                state <= h_stop;
              end else begin
                bidx <= bidx + 2'h1;
              end
            end else begin
              bi <= bi + 4'h1;
            end
          end
        end
        h_stop: begin
          if (ph == `PH_SDA_CHANGE) begin
            sda_oe <= 1'b1;
          end else if (ph == `PH_STOP_RELEASE) begin
            sda_oe <= 1'b0;
          end
          if (ph == `PH_LAST) begin
            state <= h_idle;
            rsp_valid <= 1'b1;
            rsp_data <= rd ? rxsh : 8'h00;
            rsp_nack <= nack;
          end
        end
        default: state <= h_idle;
      endcase
    end
  end
endmodule : temp_mon_host

// ==== rtl/temp_mon_pkg.sv ====
// types shared by both ends of the temperature monitor link
// assumes temp_mon_cfg.svh holds every number
package temp_mon_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_tx, st_tx_ack} dev_state_e;
  typedef enum logic [1:0] {h_idle, h_start, h_byte, h_stop} host_state_e;
endpackage : temp_mon_pkg

// ==== tb/temp_link_monitor.sv ====
// checker on the two-wire link between the host end and the monitor end
// assumes every link wire is sampled by the one system clock
`timescale 1ns/1ps
module temp_link_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // link wires
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence start_seq;
    $fell(sda) && scl;
  endsequence
  sequence stop_seq;
    $rose(sda) && scl;
  endsequence
  sequence low_phase;
    (!scl) [*8] ##1 scl;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  host_start_a: assert property (start_seq |-> host_sda_oe)
    else $error("start not made by host");
  start_frame_a: assert property (start_seq |-> scl [*6] ##[1:4] !scl)
    else $error("start not followed by first bit");
  stop_idle_a: assert property (stop_seq |-> scl [*8])
    else $error("clock not idle after stop");
  scl_low_a: assert property ($fell(scl) |-> low_phase)
    else $error("clock low phase not eight cycles");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  // open drain: pull low only, and never both ends while clock high
  open_drain_a: assert property (!host_sda_o && !dev_sda_o &&
    !(host_sda_oe && dev_sda_oe && scl))
    else $error("data wire driven high or by both ends");
  dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved data while clock high");
  sda_hold_a: assert property (
    scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe))
    else $error("data changed while clock high");
endmodule : temp_link_monitor

// ==== tb/temp_monitor_register_bank_test.sv ====
// bench joining host end and monitor end over one link interface
// assumes the host end masks config and rate data as the devices expect
`timescale 1ns/1ps
`include "temp_mon_cfg.svh"
module temp_monitor_register_bank_test import temp_mon_pkg::*;;
  localparam int TICK = 20;
  logic sys_clk, arst_n, cmd_valid, cmd_ready, cmd_read, cmd_ptr_only;
  logic rsp_valid, rsp_nack, conv_start, avg_en, range_ext, conv_done;
  logic overtemp_out_n, pin6_out_n, prev_scl, prev_sda;
  byte_t cmd_ptr, cmd_data, rsp_data, sniff, v;
  byte_t local_result, remote_result_hi, remote_result_lo;
  int nbits = 8, n_fail, samples_checked, t, seen;
  // rows: write address, write data, read address, expected read
  logic [31:0] rows [17] = '{32'h09BF_03A4, 32'h0AF3_0403, 32'h0B50_0550,
    32'h0C11_0611, 32'h0D60_0760, 32'h0E05_0805, 32'h3040_3040,
    32'h3180_3180, 32'h3270_3270, 32'h3371_3371, 32'h2103_2103,
    32'h0077_0000, 32'h0155_0100, 32'h1055_1000, 32'h0599_0550,
    32'h7F12_7F00, 32'h0904_0550};
  // local value and expected pin 6 level in alert mode
  logic [15:0] pin_rows [4] = '{16'h1100, 16'h1201, 16'h5001, 16'h5100};
  ////////////////////////////////////////////////////////////////////////////
  temp_link_if link ();
  temp_mon_host temp_mon_host_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_ptr_only(cmd_ptr_only), .cmd_ptr(cmd_ptr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack),
    .link(link));
  temp_mon_dev #(.BASE_TICK_CYCLES(TICK)) temp_mon_dev_i (.sys_clk(sys_clk),
    .arst_n(arst_n), .link(link), .conv_start(conv_start), .avg_en(avg_en),
    .range_ext(range_ext), .conv_done(conv_done),
    .local_result(local_result), .remote_result_hi(remote_result_hi),
    .remote_result_lo(remote_result_lo), .overtemp_out_n(overtemp_out_n),
    .pin6_out_n(pin6_out_n));
  temp_link_monitor temp_link_monitor_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .scl(link.scl), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // sniffer keeps the first byte after each start, as seen on the wire
  always @(posedge sys_clk) begin
    prev_scl <= link.scl;
    prev_sda <= link.sda;
    if (link.scl && prev_scl && prev_sda && !link.sda) begin
      nbits <= 0;
    end else if (link.scl && !prev_scl && nbits < 8) begin
      sniff <= {sniff[6:0], link.sda};
      nbits <= nbits + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  task automatic do_reset;
    arst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    arst_n = 1'b1;
  endtask : do_reset
  task automatic xfer(input logic r, input logic po, input byte_t p,
    input byte_t d);
    int n;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_read = r;
    cmd_ptr_only = po;
    cmd_ptr = p;
    cmd_data = d;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    chk(cmd_ready, 1'b0);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(rsp_valid, 1'b1);
    chk(cmd_ready, 1'b1);
    chk(rsp_nack, 1'b0);
    chk(sniff, {`DEV_ADDR, r});
  endtask : xfer
  task automatic rd_reg(input byte_t a, output byte_t q);
    xfer(1'b0, 1'b1, a, 8'h00);
    xfer(1'b1, 1'b0, 8'h00, 8'h00);
    q = rsp_data;
  endtask : rd_reg
  task automatic conv(input byte_t l, input byte_t h, input byte_t lo);
    @(negedge sys_clk);
    local_result = l;
    remote_result_hi = h;
    remote_result_lo = lo;
    conv_done = 1'b1;
    @(negedge sys_clk);
    conv_done = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask : conv
  task automatic wait_conv(output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (conv_start !== 1'b1 && n < 3000);
  endtask : wait_conv
  ////////////////////////////////////////////////////////////////////////////
  // whole run is near 31k cycles; over twice that means a hang
  initial begin
    #1500000;
    n_fail++;
    wrap_up();
  end
  initial begin
    {arst_n, cmd_valid, cmd_read, cmd_ptr_only, conv_done} = 5'h00;
    {cmd_ptr, cmd_data, local_result} = 24'h0000_00;
    {remote_result_hi, remote_result_lo} = 16'h0000;
    {n_fail, samples_checked} = {32'd0, 32'd0};
    do_reset();
    for (int i = 0; i < 17; i++) begin
      xfer(1'b0, 1'b0, rows[i][31:24], rows[i][23:16]);
      rd_reg(rows[i][15:8], v);
      chk(v, rows[i][7:0]);
    end
    xfer(1'b0, 1'b1, 8'h21, 8'h00);
    xfer(1'b1, 1'b0, 8'h00, 8'h00);
    chk(rsp_data, 8'h03);
    for (int c = 10; c >= 6; c--) begin
      xfer(1'b0, 1'b0, 8'h0A, 8'(c));
      wait_conv(t);
      wait_conv(t);
      chk(16'(t), 16'(TICK << (10 - c)));
      chk(avg_en, c <= 7);
    end
    // reserved rate code runs at the fastest rate
    xfer(1'b0, 1'b0, 8'h0A, 8'h0F);
    wait_conv(t);
    wait_conv(t);
    chk(16'(t), 16'(TICK));
    // standby: timer halted, link and outputs still live
    xfer(1'b0, 1'b0, 8'h09, 8'h44);
    chk(range_ext, 1'b1);
    seen = 0;
    repeat (400) begin
      @(negedge sys_clk);
      if (conv_start === 1'b1) seen++;
    end
    chk(16'(seen), 16'h0000);
    rd_reg(8'h03, v);
    chk(v, 8'h44);
    xfer(1'b0, 1'b0, 8'h32, 8'h30);
    xfer(1'b0, 1'b0, 8'h21, 8'h05);
    conv(8'h31, 8'h20, 8'h40);
    chk(overtemp_out_n, 1'b0);
    conv(8'h2C, 8'h20, 8'h40);
    chk(overtemp_out_n, 1'b0);
    conv(8'h2B, 8'h20, 8'h40);
    chk(overtemp_out_n, 1'b1);
    xfer(1'b0, 1'b0, 8'h32, 8'h20);
    chk(overtemp_out_n, 1'b0);
    rd_reg(8'h10, v);
    chk(v, 8'h40);
    conv(8'h10, 8'h72, 8'h00);
    chk(overtemp_out_n, 1'b0);
    for (int i = 0; i < 4; i++) begin
      conv(pin_rows[i][15:8], 8'h20, 8'h00);
      chk(pin6_out_n, pin_rows[i][0]);
    end
    xfer(1'b0, 1'b0, 8'h09, 8'hC4);
    chk(pin6_out_n, 1'b1);
    xfer(1'b0, 1'b0, 8'h09, 8'hE4);
    chk(pin6_out_n, 1'b0);
    conv(8'h4C, 8'h20, 8'h00);
    chk(pin6_out_n, 1'b0);
    conv(8'h4B, 8'h20, 8'h00);
    chk(pin6_out_n, 1'b1);
    // second reset with the pointer left away from zero
    xfer(1'b0, 1'b1, 8'h04, 8'h00);
    do_reset();
    chk(overtemp_out_n, 1'b1);
    xfer(1'b1, 1'b0, 8'h00, 8'h00);
    chk(rsp_data, 8'h00);
    rd_reg(8'h04, v);
    chk(v, 8'h08);
    rd_reg(8'h03, v);
    chk(v, 8'h00);
    rd_reg(8'h21, v);
    chk(v, 8'h0A);
    rd_reg(8'h01, v);
    chk(v, 8'h00);
    wrap_up();
  end
endmodule : temp_monitor_register_bank_test
